// *** inc/dxp_pkg.sv ***
/*
 * constants and carrier types for the x16 ddr psram bus slave.
 * assumes one system clock of 125 MHz sampling a slower host bus clock.
 */
package dxp_pkg;
    // command/address layout
    localparam int CA_BITS = 48;
    localparam int CA_EDGES = 6;
    localparam int CA_DIR_BIT = 47;
    localparam int CA_SPACE_BIT = 46;
    localparam int CA_BURST_BIT = 45;
    localparam int CA_ROW_HI = 44;
    localparam int CA_ROW_LO = 16;
    localparam int CA_COL_HI = 2;
    // initial latency in host clocks, doubled when a refresh is pending
    localparam logic [7:0] LAT_CLOCKS = 8'h07;
    localparam logic [7:0] LAT_EDGES = 8'h0e;
    localparam logic [7:0] LAT_EDGES_EXTRA = 8'h1c;
    // smallest wrap group in double words; size select shifts it up
    localparam logic [31:0] WRAP_BASE = 32'h00000008;
    localparam logic [15:0] DQ_RESET = 16'h0000;
    localparam logic [1:0] STROBE_RESET = 2'h0;
    localparam int BUF_DEPTH = 2;

    // one array access: a 32-bit double word and four lane masks
    typedef struct packed {
        logic [31:0] addr;
        logic we;
        logic [31:0] data;
        logic [3:0] mask;
    } dxp_req_t;

    typedef enum logic [2:0] {ST_IDLE, ST_CA, ST_LAT, ST_WR, ST_RD} dxp_state_t;
endpackage

// *** rtl/dxp_buf.sv ***
/*
 * two-entry valid/ready buffer; head entry drives the output directly.
 * assumes both sides on the same clock.
 */
`timescale 1ns/1ps
module dxp_buf #(
    parameter int WIDTH = 8
) (
    input logic clk,
    input logic reset,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic v1;
    logic [WIDTH-1:0] d1;
    logic push;
    logic pop;

    assign in_ready = !v1;
    assign push = in_valid && !v1;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
            v1 <= 1'b0;
            out_data <= '0;
            d1 <= '0;
        end else if (pop) begin
            out_valid <= v1 || push;
            out_data <= v1 ? d1 : in_data;
            v1 <= v1 && push;
            if (v1 && push) begin
                d1 <= in_data;
            end
        end else if (push) begin
            if (!out_valid) begin
                out_valid <= 1'b1;
                out_data <= in_data;
            end else begin
                v1 <= 1'b1;
                d1 <= in_data;
            end
        end
    end
endmodule

// *** rtl/dxp_slave.sv ***
/*
 * device side of a 16-bit ddr psram bus: frames, command/address capture,
 * latency flag, read strobe and write mask, burst address sequencing.
 * assumes an array behind a valid/ready request port that answers a read
 * within three system clocks; host clock at most a tenth of clk.
 */
// Notes on behaviour
// - strobe pins are outputs during command/address, flagging extra latency.
// - pending refresh drives strobe high and doubles latency; otherwise low.
// - read data is driven edge-aligned with a toggling read strobe.
// - write lanes sampled with strobe high are masked, low are written.
// - write data is captured on host clock transitions.
// - bursts advance one double word per host clock.
// - burst type is taken from each command, no reconfiguration.
// - wrapped bursts stay inside the aligned group and wrap to its start.
// - linear bursts increment until chip select rises.
// - linear reads request the next word while the current one transfers.
// - sixteen bits per edge, thirty-two per clock are accepted on writes.
// - each address selects a 32-bit double word.
// - row and burst type come first, word in third clock, then latency.
// - chip select falling starts a transaction, rising ends it.
// - a stopped host clock between transactions causes no harm.
// - differential clock level is taken from true and complement crossing.
// - low byte lanes carry command/address, high lanes only data.
// - strobe lane zero qualifies low byte, lane one the high byte.
// - hardware reset low returns to standby with pins released.
// - command bit 47 high reads, low writes.
// - command bit 46 selects memory or register space.
// - command bit 45 low wraps, high runs linear.
`timescale 1ns/1ps
module dxp_slave
    import dxp_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic cs_n,
    input logic bus_clock,
    input logic clock_complement,
    input logic diff_clock_en,
    input logic hw_reset_n,
    input logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input logic [1:0] rw_strobe_lanes_in,
    output logic [1:0] rw_strobe_lanes_out,
    output logic rw_strobe_lanes_oe,
    input logic refresh_pending,
    input logic [1:0] wrap_size_sel,
    output dxp_req_t arr_req,
    output logic arr_req_valid,
    input logic arr_req_ready,
    input logic [31:0] arr_rdata,
    input logic arr_rvalid,
    output logic busy,
    output logic overrun
);
    logic [1:0] cs_s, ck_s, ckc_s, rst_s;
    logic [15:0] dq_s1, dq_s2;
    logic [1:0] rws_s1, rws_s2;
    logic cs_prev, ck_lvl, ck_prev;
    logic cs_fall, ck_rise, ck_fall, ck_edge, ck_next;
    dxp_state_t state;
    logic [7:0] edge_cnt;
    logic [CA_BITS-1:0] ca;
    logic [CA_BITS-1:0] next_ca;
    logic lat_extra, is_read, is_reg, linear;
    logic [31:0] addr, base;
    logic [31:0] next_addr;
    logic [31:0] wmask;
    logic [15:0] lo_data;
    logic [1:0] lo_mask;
    logic [31:0] rd_word, rd_now;
    dxp_req_t buf_in;
    logic buf_in_valid, buf_in_ready;
    logic [7:0] lat_total;
    logic ca_done, lat_done;

    // every pin passes two flops before any logic looks at it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_s <= 2'h3;
            ck_s <= 2'h0;
            ckc_s <= 2'h3;
            rst_s <= 2'h0;
            dq_s1 <= DQ_RESET;
            dq_s2 <= DQ_RESET;
            rws_s1 <= STROBE_RESET;
            rws_s2 <= STROBE_RESET;
        end else begin
            cs_s <= {cs_s[0], cs_n};
            ck_s <= {ck_s[0], bus_clock};
            ckc_s <= {ckc_s[0], clock_complement};
            rst_s <= {rst_s[0], hw_reset_n};
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            rws_s1 <= rw_strobe_lanes_in;
            rws_s2 <= rws_s1;
        end
    end

    // in differential mode the level only changes once the pair has crossed
    always_comb begin
        ck_next = ck_lvl;
        if (!diff_clock_en) begin
            ck_next = ck_s[1];
        end else if (ck_s[1] && !ckc_s[1]) begin
            ck_next = 1'b1;
        end else if (!ck_s[1] && ckc_s[1]) begin
            ck_next = 1'b0;
        end
    end

    // edges are found from samples, so a halted host clock simply adds none
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ck_lvl <= 1'b0;
            ck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            ck_lvl <= ck_next;
            ck_prev <= ck_lvl;
            cs_prev <= cs_s[1];
        end
    end

    assign ck_rise = ck_lvl && !ck_prev;
    assign ck_fall = !ck_lvl && ck_prev;
    assign ck_edge = ck_rise || ck_fall;
    assign cs_fall = cs_prev && !cs_s[1];
    assign next_ca = {ca[CA_BITS-9:0], dq_s2[7:0]};
    assign lat_total = lat_extra ? LAT_EDGES_EXTRA : LAT_EDGES;
    assign ca_done = (state == ST_CA) && ck_edge && (edge_cnt == 8'(CA_EDGES - 1));
    assign lat_done = (state == ST_LAT) && ck_edge && (edge_cnt == lat_total - 8'h01);
    assign wmask = (WRAP_BASE << wrap_size_sel) - 32'h00000001;
    assign rd_now = (arr_rvalid && !is_reg) ? arr_rdata : rd_word; // a stalled answer may land on the rise itself

    always_comb begin
        if (linear) begin
            next_addr = addr + 32'h00000001;
        end else begin
            next_addr = (addr & ~wmask) | ((addr + 32'h00000001) & wmask);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            edge_cnt <= 8'h00;
        end else if (!rst_s[1] || cs_s[1]) begin
            state <= ST_IDLE;
            edge_cnt <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state <= ST_CA;
                        edge_cnt <= 8'h00;
                    end
                end
                ST_CA: begin
                    if (ca_done) begin
                        state <= ST_LAT;
                        edge_cnt <= 8'h00;
                    end else if (ck_edge) begin
                        edge_cnt <= edge_cnt + 8'h01;
                    end
                end
                ST_LAT: begin
                    if (lat_done) begin
                        state <= is_read ? ST_RD : ST_WR;
                    end else if (ck_edge) begin
                        edge_cnt <= edge_cnt + 8'h01;
                    end
                end
                ST_WR, ST_RD: begin
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // command capture and decode; burst type is latched per command
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ca <= '0;
            lat_extra <= 1'b0;
            is_read <= 1'b0;
            is_reg <= 1'b0;
            linear <= 1'b0;
            base <= 32'h00000000;
        end else if (state == ST_IDLE && cs_fall) begin
            lat_extra <= refresh_pending;
        end else if (state == ST_CA && ck_edge) begin
            ca <= next_ca;
            if (ca_done) begin
                is_read <= next_ca[CA_DIR_BIT];
                is_reg <= next_ca[CA_SPACE_BIT];
                linear <= next_ca[CA_BURST_BIT];
                base <= {next_ca[CA_ROW_HI:CA_ROW_LO], next_ca[CA_COL_HI:0]};
            end
        end
    end

    // burst address: one double word per host clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr <= 32'h00000000;
        end else if (ca_done) begin
            addr <= {next_ca[CA_ROW_HI:CA_ROW_LO], next_ca[CA_COL_HI:0]};
        end else if ((state == ST_WR || state == ST_RD) && ck_fall) begin
            addr <= next_addr;
        end
    end

    // array requests: writes per clock, reads one word ahead of the bus
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buf_in <= '0;
            buf_in_valid <= 1'b0;
            lo_data <= 16'h0000;
            lo_mask <= 2'h0;
        end else begin
            buf_in_valid <= 1'b0;
            if (state == ST_WR && ck_rise) begin
                lo_data <= dq_s2;
                lo_mask <= rws_s2;
            end
            if (state == ST_WR && ck_fall && !is_reg) begin
                buf_in_valid <= 1'b1;
                buf_in <= '{addr: addr, we: 1'b1, data: {dq_s2, lo_data}, mask: {rws_s2, lo_mask}};
            end
            if (!is_reg && ((lat_done && is_read) || (state == ST_RD && ck_fall))) begin
                buf_in_valid <= 1'b1;
                buf_in <= '{addr: lat_done ? addr : next_addr, we: 1'b0, data: 32'h00000000, mask: 4'h0};
            end
        end
    end

    // a word offered while the buffer is full is lost; flag it sticky
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overrun <= 1'b0;
        end else if (buf_in_valid && !buf_in_ready) begin
            overrun <= 1'b1;
        end
    end

    // register space is not backed here and reads back as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_word <= 32'h00000000;
        end else if (lat_done) begin
            rd_word <= 32'h00000000;
        end else if (arr_rvalid && !is_reg) begin
            rd_word <= arr_rdata;
        end
    end

    // pin drive: latency flag, read strobe, released under hardware reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dq_out <= DQ_RESET;
            dq_oe <= 1'b0;
            rw_strobe_lanes_out <= STROBE_RESET;
            rw_strobe_lanes_oe <= 1'b0;
            busy <= 1'b0;
        end else if (!rst_s[1] || cs_s[1]) begin
            dq_oe <= 1'b0;
            rw_strobe_lanes_oe <= 1'b0;
            rw_strobe_lanes_out <= STROBE_RESET;
            busy <= 1'b0;
        end else begin
            busy <= state != ST_IDLE;
            case (state)
                ST_CA: begin
                    rw_strobe_lanes_oe <= 1'b1;
                    rw_strobe_lanes_out <= {2{lat_extra}};
                end
                ST_LAT: begin
                    rw_strobe_lanes_oe <= is_read;
                    rw_strobe_lanes_out <= STROBE_RESET;
                end
                ST_RD: begin
                    dq_oe <= 1'b1;
                    rw_strobe_lanes_oe <= 1'b1;
                    if (ck_rise) begin
                        dq_out <= rd_now[15:0];
                        rw_strobe_lanes_out <= 2'h3;
                    end else if (ck_fall) begin
                        dq_out <= rd_word[31:16];
                        rw_strobe_lanes_out <= 2'h0;
                    end
                end
                default: begin
                    dq_oe <= 1'b0;
                    rw_strobe_lanes_oe <= 1'b0;
                end
            endcase
        end
    end

    dxp_buf #(
        .WIDTH($bits(dxp_req_t))
    ) u_buf (
        .clk(clk),
        .reset(reset),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(arr_req_valid),
        .out_ready(arr_req_ready),
        .out_data(arr_req)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_ca_strobe_out: assert property (state == ST_CA && cs_s[1] == 1'b0 && rst_s[1] |=>
        rw_strobe_lanes_oe)
        else $error("strobe not driven in command phase");
    a_latency_flag: assert property (state == ST_IDLE && cs_fall && !cs_s[1] && rst_s[1] ##1
        (state == ST_CA && !cs_s[1] && rst_s[1]) |=> rw_strobe_lanes_out == {2{$past(refresh_pending, 2)}})
        else $error("latency flag does not follow refresh");
    a_read_strobe: assert property (state == ST_RD && ck_rise && !cs_s[1] && rst_s[1] |=>
        rw_strobe_lanes_out == 2'h3 && dq_out == $past(rd_now[15:0]))
        else $error("read strobe or data misaligned");
    a_write_mask: assert property (state == ST_WR && ck_fall && !is_reg && !cs_s[1] && rst_s[1] |=>
        buf_in_valid && buf_in.mask[3:2] == $past(rws_s2) && buf_in.mask[1:0] == $past(lo_mask))
        else $error("write mask lanes wrong");
    a_linear_step: assert property ((state == ST_WR || state == ST_RD) && ck_fall && linear
        && !ca_done |=> addr == $past(addr) + 32'h00000001)
        else $error("linear burst did not increment");
    a_wrap_group: assert property ((state == ST_WR || state == ST_RD) && !linear
        |-> (addr & ~wmask) == (base & ~wmask))
        else $error("wrapped burst left its group");
    a_ca_six_edges: assert property (ca_done && !cs_s[1] && rst_s[1] |=> state == ST_LAT)
        else $error("latency not entered after six edges");
    a_cs_end: assert property (cs_s[1] |=> state == ST_IDLE ##1 !dq_oe)
        else $error("chip select high did not end transaction");
    a_hw_reset: assert property (!rst_s[1] |=> !dq_oe && !rw_strobe_lanes_oe)
        else $error("pins driven during hardware reset");

    c_read: cover property (state == ST_RD && ck_fall);
    c_write: cover property (state == ST_WR && buf_in_valid);
    c_extra_lat: cover property (state == ST_LAT && lat_extra && lat_done);
    c_wrap: cover property (state == ST_RD && !linear && ck_fall && ((addr + 32'h00000001) & wmask) == 32'h00000000);
endmodule

// *** verif/dxp_host.sv ***
/*
 * host controller model: frames, command bytes, latency wait, masked write
 * data and read capture. assumes the bench resolves shared pins from enables.
 */
`timescale 1ns/1ps
module dxp_host (
    input wire logic clk,
    input wire logic [15:0] dq_w,
    input wire logic [1:0] strobe_w,
    input wire logic strobe_oe,
    output logic cs_n,
    output logic bus_clock,
    output logic clock_complement,
    output logic [15:0] dq_h,
    output logic [1:0] strobe_h
);
    logic [17:0] hq[$];
    logic [1:0] lat_flag;
    logic lat_oe;
    logic cap;
    logic space;

    initial begin
        cs_n = 1'b1;
        bus_clock = 1'b0;
        clock_complement = 1'b1;
        dq_h = 16'h0000;
        strobe_h = 2'h0;
        cap = 1'b0;
        space = 1'b0;
    end

    // data set three clocks ahead of the edge, held two after: centred
    task automatic half(input logic [15:0] d, input logic [1:0] s, input logic tg);
        @(posedge clk);
        dq_h <= d;
        strobe_h <= s;
        repeat (2) @(posedge clk);
        @(negedge clk);
        if (cap)
            hq.push_back({strobe_w, dq_w});
        @(posedge clk);
        bus_clock <= bus_clock ^ tg;
        clock_complement <= ~(bus_clock ^ tg);
        @(posedge clk);
    endtask

    task automatic xfer(input logic rd, input logic lin, input logic [31:0] a, input int n,
                        input logic [31:0] wd[16], input logic [3:0] wm[16]);
        logic [47:0] ca;
        ca = {rd, space, lin, a[31:3], 13'h0000, a[2:0]};
        hq.delete();
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            half({8'h00, ca[47 - 8 * i -: 8]}, ~strobe_h, 1'b1);
            if (i == 1) begin
                lat_flag = strobe_w;
                lat_oe = strobe_oe;
            end
        end
        repeat ((lat_flag[0] === 1'b1) ? 28 : 14)
            half(16'h0000, ~strobe_h, 1'b1);
        for (int w = 0; w < 2 * n; w++) begin
            if (rd)
                half(~dq_h, ~strobe_h, 1'b1);
            else
                half(w[0] ? wd[w / 2][31:16] : wd[w / 2][15:0], w[0] ? wm[w / 2][3:2] : wm[w / 2][1:0], 1'b1);
            cap = rd;
        end
        half(~dq_h, ~strobe_h, 1'b0);
        cap = 1'b0;
        @(posedge clk);
        cs_n <= 1'b1;
        dq_h <= ~dq_h;
        repeat (6) @(posedge clk);
    endtask
endmodule

// *** verif/dxp_slave_bench.sv ***
/*
 * self-checking bench for the bus slave: random and corner transactions,
 * array model with stalls, hardware reset abort, buffer overrun.
 * assumes the host model drives the bus pins.
 */
`timescale 1ns/1ps
module dxp_slave_bench
    import dxp_pkg::*;
    ;
    logic clk, reset, cs_n, bus_clock, clock_complement, diff_clock_en, hw_reset_n;
    logic [15:0] dq_in, dq_out, dq_h;
    logic dq_oe, strobe_oe, refresh_pending, arr_req_valid, arr_req_ready;
    logic [1:0] strobe_in, strobe_out, strobe_h, wrap_size_sel, rdy_cnt;
    dxp_req_t arr_req;
    logic [31:0] arr_rdata, pa, r, seed;
    logic [31:0] zd[16];
    logic [3:0] zm[16];
    logic arr_rvalid, busy, overrun, p1, stall;
    dxp_req_t req_q[$];
    int err_total, tests_run;

    assign dq_in = dq_oe ? dq_out : dq_h;
    assign strobe_in = strobe_oe ? strobe_out : strobe_h;

    dxp_slave u_dxp_slave (.clk(clk), .reset(reset), .cs_n(cs_n), .bus_clock(bus_clock),
        .clock_complement(clock_complement), .diff_clock_en(diff_clock_en), .hw_reset_n(hw_reset_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rw_strobe_lanes_in(strobe_in),
        .rw_strobe_lanes_out(strobe_out), .rw_strobe_lanes_oe(strobe_oe), .refresh_pending(refresh_pending),
        .wrap_size_sel(wrap_size_sel), .arr_req(arr_req), .arr_req_valid(arr_req_valid),
        .arr_req_ready(arr_req_ready), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid), .busy(busy),
        .overrun(overrun));

    dxp_host u_dxp_host (.clk(clk), .dq_w(dq_in), .strobe_w(strobe_in), .strobe_oe(strobe_oe),
        .cs_n(cs_n), .bus_clock(bus_clock), .clock_complement(clock_complement), .dq_h(dq_h),
        .strobe_h(strobe_h));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] pat(input logic [31:0] x);
        return (x * 32'h9e3779b1) ^ 32'h00c3a5f0;
    endfunction

    function automatic logic [31:0] nxt(input logic [31:0] a, input logic lin, input logic [1:0] sel);
        logic [31:0] g;
        g = (WRAP_BASE << sel) - 32'h1;
        return lin ? a + 32'h1 : (a & ~g) | ((a + 32'h1) & g);
    endfunction

    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // array answers two clocks after acceptance; ready drops one cycle in four
    always @(posedge clk) begin
        rdy_cnt <= rdy_cnt + 2'h1;
        arr_req_ready <= !stall && rdy_cnt != 2'h3;
        p1 <= arr_req_valid && arr_req_ready && !arr_req.we;
        pa <= arr_req.addr;
        arr_rvalid <= p1;
        arr_rdata <= p1 ? pat(pa) : ~arr_rdata;
        if (arr_req_valid && arr_req_ready)
            req_q.push_back(arr_req);
    end

    task automatic run(input logic rd, input logic lin, input logic [31:0] a0, input int n, input logic [31:0] q);
        logic [31:0] wd[16];
        logic [3:0] wm[16];
        logic [31:0] a, e;
        @(posedge clk);
        refresh_pending <= q[2];
        wrap_size_sel <= q[5:4];
        diff_clock_en <= q[6];
        for (int i = 0; i < 16; i++) begin
            wd[i] = rnd();
            wm[i] = wd[i][7:4] ^ wd[i][3:0];
        end
        req_q.delete();
        u_dxp_host.xfer(rd, lin, a0, n, wd, wm);
        check(u_dxp_host.lat_flag, {2{q[2]}});
        check(u_dxp_host.lat_oe, 1'b1);
        check(busy, 1'b0);
        if (!rd && !stall)
            check(72'(req_q.size()), 72'(n));
        a = a0;
        for (int i = 0; i < n; i++) begin
            e = pat(a);
            if (rd) begin
                check(u_dxp_host.hq[2 * i], {2'h3, e[15:0]});
                check(u_dxp_host.hq[2 * i + 1], {2'h0, e[31:16]});
            end else if (!stall)
                check(req_q[i], {a, 1'b1, wd[i], wm[i]});
            a = nxt(a, lin, q[5:4]);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        wrap_up();
    end

    initial begin
        seed = 32'h2a6ab513;
        reset = 1'b1;
        diff_clock_en = 1'b0;
        hw_reset_n = 1'b1;
        refresh_pending = 1'b0;
        wrap_size_sel = 2'h0;
        stall = 1'b0;
        rdy_cnt = 2'h0;
        arr_req_ready = 1'b0;
        arr_rdata = 32'h0;
        arr_rvalid = 1'b0;
        p1 = 1'b0;
        pa = 32'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check({dq_oe, strobe_oe, overrun, arr_req_valid}, 4'h0);
        // first two: wrapped read from 0x107, linear across the top address
        for (int t = 0; t < 12; t++) begin
            r = rnd();
            run(t < 2 || r[0], t == 1 || (t > 1 && r[1]),
                t == 0 ? 32'h0000_0107 : t == 1 ? 32'hffff_fffe : rnd(), 3 + r[10:8], r);
        end
        fork
            u_dxp_host.xfer(1'b1, 1'b1, 32'h0000_0040, 8, zd, zm);
            begin
                repeat (110) @(posedge clk);
                hw_reset_n <= 1'b0;
                repeat (6) @(posedge clk);
                check({dq_oe, strobe_oe}, 2'h0);
                hw_reset_n <= 1'b1;
            end
        join
        repeat (4) @(posedge clk);
        run(1'b0, 1'b0, 32'h0000_0086, 5, 32'h0000_0014);
        // register space: reads give zero, writes raise no array request
        u_dxp_host.space = 1'b1;
        u_dxp_host.xfer(1'b1, 1'b0, 32'h0000_0010, 2, zd, zm);
        for (int i = 0; i < 4; i++)
            check(u_dxp_host.hq[i], {i[0] ? 2'h0 : 2'h3, 16'h0000});
        req_q.delete();
        u_dxp_host.xfer(1'b0, 1'b0, 32'h0000_0010, 2, zd, zm);
        check(72'(req_q.size()), 72'h0);
        u_dxp_host.space = 1'b0;
        stall <= 1'b1;
        run(1'b0, 1'b1, 32'h0000_0020, 4, 32'h0);
        check(overrun, 1'b1);
        stall <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        check({overrun, dq_oe, busy}, 3'h0);
        reset <= 1'b0;
        wrap_up();
    end
endmodule
